// ==== rx_frame_filter_qos.sv ====
// receive frame qualification: classification, delivery, qos drop, free buffer
// accounting and channel teardown, with an apb register slave
// assumes frame summaries and buffer events come from logic on mclk (no sync)
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module rx_frame_filter_qos
    import rx_filter_pkg::*;
(
    input  wire logic                 mclk,
    input  wire logic                 rst,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [ADDR_W-1:0]    paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 frame_active,
    input  wire logic                 frame_done,
    input  wire logic [15:0]          frame_len,
    input  wire logic [15:0]          frame_len_type,
    input  wire logic [15:0]          frame_tci,
    input  wire logic                 frame_crc_err,
    input  wire logic                 frame_code_err,
    input  wire logic                 frame_align_err,
    input  wire logic                 frame_is_control,
    input  wire logic                 frame_addr_hit,
    input  wire logic [2:0]           frame_hit_chan,
    input  wire logic                 buffer_used,
    input  wire logic [2:0]           buffer_chan,
    output logic                      frame_accept,
    output logic                      frame_qos_drop,
    output logic [2:0]                frame_chan,
    output class_type                 frame_class,
    output logic      [15:0]          frame_xfer_len,
    output logic                      frame_keep_crc,
    output logic                      frame_high_prio,
    output logic                      teardown_done_flag,
    output logic      [2:0]           teardown_chan,
    output logic      [NUM_CHAN-1:0]  rx_chan_irq
);

    //--------------------------------------------------------------------------
    // state
    //--------------------------------------------------------------------------
    typedef struct packed {
        logic [31:0]                prdata;
        logic                       pready;
        logic                       pslverr;
        logic [2:0]                 prom_ch;
        logic                       all_en;
        logic                       err_en;
        logic                       ctl_en;
        logic                       short_en;
        logic                       pass_crc;
        logic                       qos_en;
        logic [15:0]                low_thresh;
        logic [15:0]                max_len;
        logic [NUM_CHAN-1:0]        chan_en;
        logic [NUM_CHAN-1:0]        td_pend;
        logic [NUM_CHAN-1:0]        irq;
        logic [NUM_CHAN-1:0][15:0]  free_cnt;
        logic [NUM_CHAN-1:0][31:0]  cp;
        logic [NUM_CHAN-1:0][31:0]  hdp;
        logic                       acc;
        logic                       drop;
        logic [2:0]                 out_ch;
        class_type                  cls;
        logic [15:0]                xfer_len;
        logic                       keep_crc;
        logic                       hi_prio;
        logic                       td_flag;
        logic [2:0]                 td_ch;
    } state_type;

    state_type s;
    state_type next_s;

    // eight-word banks are 32-byte aligned, the word index sits in bits 4:2
    function automatic logic bank_hit(input logic [ADDR_W-1:0] a, input logic [11:0] base);
        return a[ADDR_W-1:5] == base[ADDR_W-1:5];
    endfunction

    function automatic logic [31:0] read_mux(input state_type st, input logic [ADDR_W-1:0] a);
        logic [31:0] d;
        d = 32'h0000_0000;
        if (a == OFS_MBP_ENABLE)
            d = {22'h00_0000, st.qos_en, st.pass_crc, st.short_en, st.ctl_en, st.err_en, st.all_en,
                 1'b0, st.prom_ch};
        else if (a == OFS_LOW_THRESH)
            d = {16'h0000, st.low_thresh};
        else if (a == OFS_MAX_LEN)
            d = {16'h0000, st.max_len};
        else if (a == OFS_CHAN_ENABLE)
            d = {24'h00_0000, st.chan_en};
        else if (a == OFS_STATUS)
            d = {16'h0000, st.td_pend, st.irq};
        else if (bank_hit(a, OFS_FREE_BANK))
            d = {16'h0000, st.free_cnt[a[4:2]]};
        else if (bank_hit(a, OFS_CP_BANK))
            d = st.cp[a[4:2]];
        else if (bank_hit(a, OFS_HDP_BANK))
            d = st.hdp[a[4:2]];
        return d;
    endfunction

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        return (a[1:0] == 2'b00) &&
               (a == OFS_MBP_ENABLE || a == OFS_LOW_THRESH || a == OFS_MAX_LEN ||
                a == OFS_TEARDOWN || a == OFS_CHAN_ENABLE || a == OFS_STATUS ||
                bank_hit(a, OFS_FREE_BANK) || bank_hit(a, OFS_CP_BANK) || bank_hit(a, OFS_HDP_BANK));
    endfunction

    //--------------------------------------------------------------------------
    // next state
    //--------------------------------------------------------------------------
    logic       wr;
    logic [2:0] widx;
    logic       errd;
    logic       is_short;
    logic       is_long;
    logic       matched;
    logic       has_target;
    logic [2:0] target;
    logic       allowed;
    logic       low_prio;
    logic       found;

    always_comb
    begin
        next_s   = s;
        wr       = psel && penable && s.pready && pwrite && !s.pslverr;
        widx     = paddr[4:2];
        errd     = 1'b0;
        is_short = 1'b0;
        is_long  = 1'b0;
        matched  = 1'b0;
        has_target = 1'b0;
        target   = 3'd0;
        allowed  = 1'b0;
        low_prio = 1'b1;
        found    = 1'b0;

        // registered read data and ready: answer lands one cycle after setup
        next_s.pready  = psel && !penable;
        next_s.pslverr = psel && !penable && !mapped(paddr);
        next_s.prdata  = (psel && !penable) ? read_mux(s, paddr) : 32'h0000_0000;

        if (wr && paddr == OFS_MBP_ENABLE)
        begin
            next_s.prom_ch  = pwdata[FLD_PROM_CH_LSB +: 3];
            next_s.all_en   = pwdata[FLD_ALL_EN];
            next_s.err_en   = pwdata[FLD_ERR_EN];
            next_s.ctl_en   = pwdata[FLD_CTL_EN];
            next_s.short_en = pwdata[FLD_SHORT_EN];
            next_s.pass_crc = pwdata[FLD_PASS_CRC];
            next_s.qos_en   = pwdata[FLD_QOS_EN];
        end
        if (wr && paddr == OFS_LOW_THRESH)
            next_s.low_thresh = pwdata[15:0];
        if (wr && paddr == OFS_MAX_LEN)
            next_s.max_len = pwdata[15:0];
        if (wr && paddr == OFS_CHAN_ENABLE)
            next_s.chan_en = pwdata[NUM_CHAN-1:0];
        if (wr && bank_hit(paddr, OFS_HDP_BANK))
            next_s.hdp[widx] = pwdata;

        // free counts: host add and buffer use may land together
        for (int i = 0; i < NUM_CHAN; i++)
        begin
            if (wr && bank_hit(paddr, OFS_FREE_BANK) && widx == 3'(i))
                next_s.free_cnt[i] = 16'(s.free_cnt[i] + pwdata[15:0]); // R06
            if (buffer_used && buffer_chan == 3'(i) && next_s.free_cnt[i] != 16'h0000)
                next_s.free_cnt[i] = 16'(next_s.free_cnt[i] - 16'h0001); // R05
        end

        // completion pointer: ack with marker clears the channel interrupt
        if (wr && bank_hit(paddr, OFS_CP_BANK))
        begin
            next_s.cp[widx] = pwdata;
            if (pwdata == TD_MARKER)
                next_s.irq[widx] = 1'b0; // R12
        end

        //----------------------------------------------------------------------
        // teardown: one channel served per cycle, never while a frame is open
        //----------------------------------------------------------------------
        next_s.td_flag = 1'b0;
        if (!frame_active) // R09
        begin
            for (int i = 0; i < NUM_CHAN; i++)
            begin
                if (s.td_pend[i] && !found)
                begin
                    found             = 1'b1;
                    next_s.td_pend[i] = 1'b0;
                    if (s.chan_en[i] && s.hdp[i] != 32'h0000_0000)
                    begin
                        next_s.td_flag = 1'b1; // R09
                        next_s.td_ch   = 3'(i);
                    end
                    next_s.hdp[i] = 32'h0000_0000; // R09
                    next_s.cp[i]  = TD_MARKER; // R10
                    next_s.irq[i] = 1'b1; // R11
                end
            end
        end
        // a new command wins over the service of the same channel
        if (wr && paddr == OFS_TEARDOWN)
            next_s.td_pend[pwdata[2:0]] = 1'b1; // R08

        //----------------------------------------------------------------------
        // frame qualification
        //----------------------------------------------------------------------
        errd     = frame_crc_err || frame_code_err || frame_align_err;
        is_short = frame_len < MIN_FRAME_LEN;
        is_long  = frame_len > s.max_len;
        if (frame_len_type == TAG_PROTOCOL)
            low_prio = frame_tci[PRIO_MSB:PRIO_LSB] < 3'd4; // R01 R02
        // disabled target channels and gated control frames do not match
        matched = frame_addr_hit && s.chan_en[frame_hit_chan] &&
                  (!frame_is_control || s.ctl_en); // R20 R21
        if (matched)
        begin
            has_target = 1'b1;
            target     = frame_hit_chan;
        end
        else if (s.all_en)
        begin
            has_target = 1'b1; // R19
            target     = s.prom_ch;
        end

        if (is_short)
            allowed = errd ? (s.err_en && s.short_en) : s.short_en; // R22
        else if (is_long || errd)
            allowed = s.err_en; // R22
        else
            allowed = 1'b1;
        if (frame_is_control && !s.ctl_en)
            allowed = 1'b0; // R22

        next_s.acc  = 1'b0;
        next_s.drop = 1'b0;
        if (frame_done)
        begin
            next_s.hi_prio = !low_prio;
            next_s.out_ch  = target;
            if (is_short)
                next_s.cls = errd ? cls_fragment : cls_undersize; // R16
            else if (is_long)
                next_s.cls = errd ? cls_jabber : cls_oversize; // R14
            else
                next_s.cls = errd ? cls_error : cls_proper; // R13
            // qos only trims frames that would otherwise be delivered
            next_s.drop = has_target && allowed && s.qos_en && low_prio &&
                          s.free_cnt[target] <= s.low_thresh; // R03 R04
            next_s.acc  = has_target && allowed && !next_s.drop;
            if (is_long)
            begin
                next_s.xfer_len = s.max_len; // R18
                next_s.keep_crc = 1'b1;
            end
            else if (frame_len <= CRC_PASS_LEN)
            begin
                next_s.xfer_len = frame_len; // R17
                next_s.keep_crc = 1'b1;
            end
            else
            begin
                next_s.xfer_len = s.pass_crc ? frame_len : 16'(frame_len - CRC_BYTES);
                next_s.keep_crc = s.pass_crc;
            end
        end
    end

    //--------------------------------------------------------------------------
    // registers
    //--------------------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            s         <= '0;
            s.max_len <= MAX_LEN_RST; // R15
        end
        else
            s <= next_s;
    end

    assign prdata             = s.prdata;
    assign pready             = s.pready;
    assign pslverr            = s.pslverr;
    assign frame_accept       = s.acc;
    assign frame_qos_drop     = s.drop;
    assign frame_chan         = s.out_ch;
    assign frame_class        = s.cls;
    assign frame_xfer_len     = s.xfer_len;
    assign frame_keep_crc     = s.keep_crc;
    assign frame_high_prio    = s.hi_prio;
    assign teardown_done_flag = s.td_flag;
    assign teardown_chan      = s.td_ch;
    assign rx_chan_irq        = s.irq;

    //--------------------------------------------------------------------------
    // assertions
    //--------------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking

    a_tag_high_prio: assert property ( // R01
        disable iff (rst) frame_done && frame_len_type == TAG_PROTOCOL && frame_tci[15] |=> frame_high_prio)
        else $error("tagged priority 4-7 not high");

    a_untagged_low: assert property ( // R02
        disable iff (rst) frame_done && frame_len_type != TAG_PROTOCOL |=> !frame_high_prio)
        else $error("untagged frame marked high");

    a_qos_gate: assert property ( // R04
        disable iff (rst) frame_done && !s.qos_en |=> !frame_qos_drop)
        else $error("qos drop while qos disabled");

    a_drop_excl: assert property ( // R03
        disable iff (rst) frame_qos_drop |-> !frame_accept && !frame_high_prio
                          && $past(s.free_cnt[target]) <= $past(s.low_thresh))
        else $error("qos drop inconsistent");

    a_free_dec: assert property ( // R05
        disable iff (rst) buffer_used && !wr && s.free_cnt[buffer_chan] != 16'h0000
        |=> s.free_cnt[$past(buffer_chan)] == 16'($past(s.free_cnt[buffer_chan]) - 16'h0001))
        else $error("free count not decremented");

    a_free_add: assert property ( // R06
        disable iff (rst) wr && bank_hit(paddr, OFS_FREE_BANK) && !buffer_used
        |=> s.free_cnt[$past(widx)] == 16'($past(s.free_cnt[widx]) + $past(pwdata[15:0])))
        else $error("free count write did not add");

    a_td_clear_hdp: assert property ( // R09
        disable iff (rst) teardown_done_flag |-> s.hdp[teardown_chan] == 32'h0000_0000 && !$past(frame_active))
        else $error("teardown left head pointer");

    a_td_marker: assert property ( // R10
        disable iff (rst) $rose(rx_chan_irq[3]) |-> s.cp[3] == TD_MARKER)
        else $error("teardown irq without marker");

    a_td_keep_en: assert property ( // R11
        disable iff (rst) wr && paddr == OFS_TEARDOWN ##1 !(wr && paddr == OFS_CHAN_ENABLE)[*2]
        |-> s.chan_en == $past(s.chan_en, 2))
        else $error("teardown changed channel enable");

    a_max_len_rst: assert property ( // R15
        $fell(rst) |-> s.max_len == MAX_LEN_RST)
        else $error("max length reset wrong");

    a_short_crc: assert property ( // R17
        disable iff (rst) frame_done && frame_len <= CRC_PASS_LEN |=> frame_keep_crc && frame_xfer_len == $past(frame_len))
        else $error("short frame crc not passed");

    a_long_trunc: assert property ( // R18
        disable iff (rst) frame_done && frame_len > s.max_len |=> frame_xfer_len == $past(s.max_len)
                          && (frame_class == cls_oversize || frame_class == cls_jabber))
        else $error("long frame not truncated");

endmodule // rx_frame_filter_qos

// ==== rx_filter_pkg.sv ====
// constants, types and register map of the receive frame filter / qos block
// assumes one 40 MHz clock domain shared with the apb bus and the receive datapath
//------------------------------------------------------------------------------
// What this block does
// R01 - tag protocol 8100h: take next 16-bit word, priority is its bits 15-13
// R02 - tagged priority 0-3 low, 4-7 high; untagged frames always low
// R03 - qos on: drop low frame when channel free count <= low threshold
// R04 - qos drop only while the qos enable bit is set
// R05 - each consumed receive buffer decrements that channel's nonzero free count by one
// R06 - host write to free count adds to it; count holds up to 65535
// R07 - host loads free counts at init, then writes reclaimed buffer numbers
// R08 - host tears down a channel by writing its number, any time
// R09 - teardown: finish frame, flag next descriptor, clear head pointer, raise irq
// R10 - after teardown completion pointer reads back FFFF_FFFCh marker
// R11 - teardown of inactive channel still interrupts; channel enables never cleared
// R12 - software acknowledges teardown by writing the marker to completion pointer
// R13 - proper frame: 64 to max length bytes with no code, align, crc error
// R14 - longer than max: oversize if clean, jabber if errored
// R15 - max receive length resets to 1518
// R16 - shorter than 64: undersized if clean, fragment if errored
// R17 - frames of 20 bytes or fewer always pass their crc bytes
// R18 - long frame with error delivery transfers exactly max length bytes
// R19 - all-frames enable sends non-matching frames to promiscuous channel, else none
// R20 - address match only when the target channel is enabled
// R21 - control frames match only with control enable; error enables never affect match
// R22 - error, short, both, control enables gate the respective frame kinds
//------------------------------------------------------------------------------
package rx_filter_pkg;

    localparam int          NUM_CHAN        = 8;
    localparam int          ADDR_W          = 12;

    //--------------------------------------------------------------------------
    // register map (byte addresses)
    //--------------------------------------------------------------------------
    localparam logic [11:0] OFS_MBP_ENABLE  = 12'h000;
    localparam logic [11:0] OFS_LOW_THRESH  = 12'h004;
    localparam logic [11:0] OFS_MAX_LEN     = 12'h008;
    localparam logic [11:0] OFS_TEARDOWN    = 12'h00C;
    localparam logic [11:0] OFS_CHAN_ENABLE = 12'h010;
    localparam logic [11:0] OFS_STATUS      = 12'h014;
    localparam logic [11:0] OFS_FREE_BANK   = 12'h020;
    localparam logic [11:0] OFS_CP_BANK     = 12'h040;
    localparam logic [11:0] OFS_HDP_BANK    = 12'h060;

    // fields of rx_mcast_bcast_prom_enable_reg
    localparam int          FLD_PROM_CH_LSB = 0;
    localparam int          FLD_ALL_EN      = 4;
    localparam int          FLD_ERR_EN      = 5;
    localparam int          FLD_CTL_EN      = 6;
    localparam int          FLD_SHORT_EN    = 7;
    localparam int          FLD_PASS_CRC    = 8;
    localparam int          FLD_QOS_EN      = 9;

    //--------------------------------------------------------------------------
    // values and frame limits
    //--------------------------------------------------------------------------
    localparam logic [15:0] MAX_LEN_RST     = 16'h05EE;
    localparam logic [31:0] TD_MARKER       = 32'hFFFF_FFFC;
    localparam logic [15:0] TAG_PROTOCOL    = 16'h8100;
    localparam logic [15:0] MIN_FRAME_LEN   = 16'h0040;
    localparam logic [15:0] CRC_PASS_LEN    = 16'h0014;
    localparam logic [15:0] CRC_BYTES       = 16'h0004;
    localparam int          PRIO_MSB        = 15;
    localparam int          PRIO_LSB        = 13;

    typedef enum logic [2:0] {
        cls_proper,
        cls_error,
        cls_oversize,
        cls_jabber,
        cls_undersize,
        cls_fragment
    } class_type;

endpackage

// ==== phy_model.sv ====
// receive-side frame source standing in for the phy and the receive dma
// assumes the bench calls send, use_buf and hold from its own process
`timescale 1ns/1ps
module phy_model
(
    input  wire logic        mclk,
    output logic             frame_active,
    output logic             frame_done,
    output logic [15:0]      frame_len,
    output logic [15:0]      frame_len_type,
    output logic [15:0]      frame_tci,
    output logic             frame_crc_err,
    output logic             frame_code_err,
    output logic             frame_align_err,
    output logic             frame_is_control,
    output logic             frame_addr_hit,
    output logic [2:0]       frame_hit_chan,
    output logic             buffer_used,
    output logic [2:0]       buffer_chan
);
    //--------------------------------------------------------------------
    // frame summaries; released fields show the inverse, never a stale copy
    //--------------------------------------------------------------------
    initial
    begin
        {frame_active, frame_done, buffer_used, buffer_chan} = '0;
        {frame_len, frame_len_type, frame_tci} = '0;
        {frame_crc_err, frame_code_err, frame_align_err, frame_is_control, frame_addr_hit, frame_hit_chan} = '0;
    end
    task automatic send(input logic [15:0] len, lt, tci, input logic [2:0] err, input logic ctl, hit,
                        input logic [2:0] hc);
        @(posedge mclk);
        frame_done <= 1'b1;
        {frame_len, frame_len_type, frame_tci} <= {len, lt, tci};
        {frame_crc_err, frame_code_err, frame_align_err, frame_is_control, frame_addr_hit, frame_hit_chan} <= {err, ctl, hit, hc};
        @(posedge mclk);
        frame_done <= 1'b0;
        {frame_len, frame_len_type, frame_tci} <= ~{len, lt, tci};
        {frame_crc_err, frame_code_err, frame_align_err, frame_is_control, frame_addr_hit, frame_hit_chan} <= ~{err, ctl, hit, hc};
    endtask
    task automatic use_buf(input logic [2:0] ch);
        @(posedge mclk);
        buffer_used <= 1'b1;
        buffer_chan <= ch;
        @(posedge mclk);
        buffer_used <= 1'b0;
        buffer_chan <= ~ch;
    endtask
    task automatic hold(input logic a);
        @(posedge mclk);
        frame_active <= a;
    endtask
endmodule // phy_model

// ==== tb.sv ====
// self-checking bench: apb host, frame classification, qos, delivery, teardown
// assumes phy_model drives the frame side and the bench is the only apb master
`timescale 1ns/1ps
module tb;
    import rx_filter_pkg::*;
    logic mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, er;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, frame_active, frame_done, frame_crc_err, frame_code_err, frame_align_err;
    logic frame_is_control, frame_addr_hit, buffer_used, frame_accept, frame_qos_drop, frame_keep_crc;
    logic frame_high_prio, teardown_done_flag;
    logic [15:0] frame_len, frame_len_type, frame_tci, frame_xfer_len;
    logic [2:0] frame_hit_chan, buffer_chan, frame_chan, teardown_chan, td_ch;
    logic [NUM_CHAN-1:0] rx_chan_irq;
    class_type frame_class;
    int fail_count = 0, checks = 0, td_cnt = 0;
    localparam logic [15:0] LN [8] = '{16'h0040, 16'h05EE, 16'h05EF, 16'h05F2, 16'h003F, 16'h0014, 16'h0015, 16'h0064};
    localparam logic [15:0] XL [8] = '{16'h003C, 16'h05EA, 16'h05EE, 16'h05EE, 16'h003B, 16'h0014, 16'h0011, 16'h0060};
    localparam logic [2:0] ER [8] = '{3'h0, 3'h0, 3'h0, 3'h4, 3'h0, 3'h4, 3'h0, 3'h2};
    localparam logic KC [8] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    localparam class_type CL [8] = '{cls_proper, cls_proper, cls_oversize, cls_jabber, cls_undersize, cls_fragment,
                                      cls_undersize, cls_error};
    //--------------------------------------------------------------------
    // instances and clock
    //--------------------------------------------------------------------
    rx_frame_filter_qos rx_frame_filter_qos_inst (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .frame_active, .frame_done, .frame_len, .frame_len_type, .frame_tci, .frame_crc_err,
        .frame_code_err, .frame_align_err, .frame_is_control, .frame_addr_hit, .frame_hit_chan, .buffer_used,
        .buffer_chan, .frame_accept, .frame_qos_drop, .frame_chan, .frame_class, .frame_xfer_len, .frame_keep_crc,
        .frame_high_prio, .teardown_done_flag, .teardown_chan, .rx_chan_irq);
    phy_model phy_inst (.mclk, .frame_active, .frame_done, .frame_len, .frame_len_type, .frame_tci,
        .frame_crc_err, .frame_code_err, .frame_align_err, .frame_is_control, .frame_addr_hit,
        .frame_hit_chan, .buffer_used, .buffer_chan);
    always #12.5 mclk = ~mclk;
    // the flag stands one cycle only, so it is caught here
    always @(posedge mclk)
        if (teardown_done_flag === 1'b1)
        begin
            td_cnt  <= td_cnt + 1;
            td_ch   <= teardown_chan;
        end
    //--------------------------------------------------------------------
    // tasks
    //--------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do
            @(posedge mclk);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask
    task automatic fr(input logic [15:0] lt, tci, input logic ctl, hit, input logic [2:0] hc);
        phy_inst.send(16'h0040, lt, tci, 3'h0, ctl, hit, hc);
        #1;
    endtask
    task automatic fchk(input logic a, dr, input logic [2:0] c);
        check({frame_accept, frame_qos_drop, (frame_accept || frame_qos_drop) ? frame_chan : 3'h0}, {a, dr, c});
    endtask
    initial
    begin
        #100000;
        fail_count++;
        final_report;
    end
    //--------------------------------------------------------------------
    // tests
    //--------------------------------------------------------------------
    initial
    begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        apb(0, OFS_MAX_LEN, 0);
        check(rd, 32'h0000_05EE);
        apb(0, 12'h0FC, 0);
        check({rd[30:0], er}, 32'h0000_0001);
        apb(1, OFS_CHAN_ENABLE, 32'h0000_00FF);
        apb(1, OFS_MBP_ENABLE, 32'h0000_00A0);
        for (int i = 0; i < 8; i++)
        begin
            phy_inst.send(LN[i], 16'h0800, 16'h0000, ER[i], 1'b0, 1'b1, 3'h1);
            #1;
            check({frame_accept, frame_keep_crc, 6'(frame_class), frame_xfer_len}, {1'b1, KC[i], 6'(CL[i]), XL[i]});
        end
        fr(TAG_PROTOCOL, 16'h7FFF, 0, 1, 1);
        check(frame_high_prio, 0);
        fr(TAG_PROTOCOL, 16'h8000, 0, 1, 1);
        check(frame_high_prio, 1);
        fr(16'h0800, 16'hE000, 0, 1, 1);
        check(frame_high_prio, 0);
        apb(1, OFS_LOW_THRESH, 32'h0000_0002);
        apb(1, OFS_FREE_BANK + 12'h004, 32'h0000_0002);
        apb(1, OFS_FREE_BANK + 12'h004, 32'h0000_0001);
        apb(0, OFS_FREE_BANK + 12'h004, 0);
        check(rd, 32'h0000_0003);
        apb(1, OFS_MBP_ENABLE, 32'h0000_03A0);
        fr(16'h0800, 16'h0000, 0, 1, 1);
        fchk(1, 0, 1);
        check({frame_keep_crc, frame_xfer_len}, {1'b1, 16'h0040});
        phy_inst.use_buf(3'h1);
        apb(0, OFS_FREE_BANK + 12'h004, 0);
        check(rd, 32'h0000_0002);
        fr(16'h0800, 16'h0000, 0, 1, 1);
        fchk(0, 1, 1);
        fr(TAG_PROTOCOL, 16'hE000, 0, 1, 1);
        fchk(1, 0, 1);
        apb(1, OFS_MBP_ENABLE, 32'h0000_00A0);
        fr(16'h0800, 16'h0000, 0, 1, 1);
        fchk(1, 0, 1);
        fr(16'h0800, 16'h0000, 0, 0, 0);
        fchk(0, 0, 0);
        apb(1, OFS_MBP_ENABLE, 32'h0000_00B5);
        fr(16'h0800, 16'h0000, 0, 0, 0);
        fchk(1, 0, 5);
        apb(1, OFS_CHAN_ENABLE, 32'h0000_00FB);
        fr(16'h0800, 16'h0000, 0, 1, 2);
        fchk(1, 0, 5);
        fr(16'h8808, 16'h0000, 1, 1, 1);
        fchk(0, 0, 0);
        apb(1, OFS_MBP_ENABLE, 32'h0000_00F5);
        fr(16'h8808, 16'h0000, 1, 1, 1);
        fchk(1, 0, 1);
        apb(1, OFS_MBP_ENABLE, 32'h0000_0030);
        phy_inst.send(16'h003F, 16'h0800, 16'h0000, 3'h0, 1'b0, 1'b1, 3'h1);
        #1;
        fchk(0, 0, 0);
        apb(1, OFS_CHAN_ENABLE, 32'h0000_00FF);
        apb(1, OFS_HDP_BANK + 12'h00C, 32'h0000_1000);
        phy_inst.hold(1'b1);
        apb(1, OFS_TEARDOWN, 32'h0000_0003);
        repeat (5) @(posedge mclk);
        #1;
        check(rx_chan_irq, 0);
        phy_inst.hold(1'b0);
        repeat (4) @(posedge mclk);
        #1;
        check({4'(td_cnt), td_ch, rx_chan_irq}, {4'h1, 3'h3, 8'h08});
        apb(0, OFS_CP_BANK + 12'h00C, 0);
        check(rd, TD_MARKER);
        apb(0, OFS_HDP_BANK + 12'h00C, 0);
        check(rd, 0);
        apb(0, OFS_CHAN_ENABLE, 0);
        check(rd, 32'h0000_00FF);
        apb(1, OFS_TEARDOWN, 32'h0000_0006);
        repeat (4) @(posedge mclk);
        #1;
        check({4'(td_cnt), rx_chan_irq}, {4'h1, 8'h48});
        apb(1, OFS_CP_BANK + 12'h00C, TD_MARKER);
        check(rx_chan_irq, 8'h40);
        final_report;
    end
endmodule // tb
